// >>> rtl/plt_defs.svh
// Timing constants, test codes and command codes for the port loopback test manager.
`ifndef PLT_DEFS_SVH
`define PLT_DEFS_SVH
`define PLT_CLK_PERIOD_NS 4
`define PLT_LAMP_HALF_MS 500
`define PLT_LAMP_HALF_CYC ((`PLT_LAMP_HALF_MS * 1000000) / `PLT_CLK_PERIOD_NS)
`define PLT_MS_CYC (1000000 / `PLT_CLK_PERIOD_NS)
`define PLT_TEST_NONE 3'h0
`define PLT_TEST_PPL 3'h1
`define PLT_TEST_CRL 3'h2
`define PLT_TEST_V54 3'h3
`define PLT_TEST_FT1 3'h4
`define PLT_TEST_LAMP 3'h5
`define PLT_V54_CODE 8'hA5
`define PLT_FT1_CODE 8'h3C
`endif

// >>> rtl/plt_pkg.sv
// Types shared by the port loopback test manager.
package plt_pkg;
    typedef struct packed {
        logic lineLoop;
        logic payloadLoop;
        logic repeaterLoop;
        logic patternSend;
        logic remoteLineSend;
    } plt_ifc_state_t;

    typedef struct packed {
        logic       start;
        logic       stop;
        logic [2:0] test;
    } plt_req_t;

    typedef struct packed {
        logic dteLoop;
        logic portPayloadLoop;
        logic channelLoop;
        logic v54Send;
        logic ft1Send;
        logic lamp;
    } plt_active_t;
endpackage

// >>> rtl/plt_tick_divider.sv
// Enable pulse divider used for lamp blinking and millisecond timing.
`timescale 1ns/1ns
module plt_tick_divider #(
    parameter int DIV = 4
) (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic run,
    output logic      tick
);
    logic [31:0] cnt_reg;
    wire         atEnd = (cnt_reg == 32'(DIV - 1));

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt_reg <= 32'h0;
            tick    <= 1'b0;
        end
        else if (!run)
        begin
            cnt_reg <= 32'h0;
            tick    <= 1'b0;
        end
        else
        begin
            cnt_reg <= atEnd ? 32'h0 : cnt_reg + 32'h1;
            tick    <= atEnd;
        end
    end
endmodule // plt_tick_divider

// >>> rtl/plt_code_sender.sv
// Repeats a remote loopback command byte serially while enabled.
`timescale 1ns/1ns
module plt_code_sender (
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       enable,
    input  wire logic [7:0] code,
    output logic            bitOut
);
    logic [2:0] idx_reg;

    // The pattern is repeated MSB first so the far end can lock at any phase.
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            idx_reg <= 3'h7;
            bitOut  <= 1'b0;
        end
        else if (!enable)
        begin
            idx_reg <= 3'h7;
            bitOut  <= 1'b0;
        end
        else
        begin
            bitOut  <= code[idx_reg];
            idx_reg <= idx_reg - 3'h1;
        end
    end
endmodule // plt_code_sender

// >>> rtl/plt_loop_manager.sv
// Port loopback paths, remote loopback senders, interlocks and lamp test.
`timescale 1ns/1ns
`include "plt_defs.svh"

// Behaviour
// (R1) DTE loopback returns DTE data to DTE
// (R2) Port payload loop returns network data
// (R3) Lead-held DTE loop ignores abort and timeout
// (R4) Port payload loop refused on port conflicts
// (R5) Channel loop returns data before customer
// (R6) Channel loop refused on interface conflicts
// (R7) V.54 send transmits its command code
// (R8) V.54 send refused on conflicts
// (R9) FT1 send transmits its command code
// (R10) FT1 send refused on conflicts
// (R11) Lamp test toggles all LEDs each half-second
// (R12) Lamp end restores normal LED state
// (R13) Enabled timeout stops lamp test
// (R14) One-step interlock check, refusal changes nothing
module plt_loop_manager
    import plt_pkg::*;
#(
    parameter int LED_N     = 8,
    parameter int LAMP_HALF = `PLT_LAMP_HALF_CYC,
    parameter int MS_CYC    = `PLT_MS_CYC
) (
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    input  wire plt_req_t         req,
    input  wire logic             dteLoopReq,
    input  wire logic             dteLoopLead,
    input  wire logic             abortAll,
    input  wire plt_ifc_state_t   ifcState,
    input  wire logic             timeoutEn,
    input  wire logic [15:0]      durationMs,
    input  wire logic             dteRxData,
    input  wire logic             netRxData,
    input  wire logic             portTxData,
    input  wire logic             portRxData,
    input  wire logic [LED_N-1:0] ledNormal,
    output logic                  dteTxData,
    output logic                  netTxData,
    output logic [LED_N-1:0]      ledOut,
    output plt_active_t           active,
    output logic                  reqRefused,
    output logic                  reqAccepted
);
    plt_active_t act_reg;
    plt_active_t act_next;
    logic        ledPhase_reg;
    logic [15:0] msCount_reg;
    logic        lampTick;
    logic        msTick;
    logic        v54Bit;
    logic        ft1Bit;
    logic        dteLoopSw_reg;

    // The DTE loop comes from either software or the interface lead.
    wire dteLoopNow = dteLoopSw_reg | dteLoopLead;

    // All conflicts are evaluated against the same registered state, except the DTE loop term of pplBlock, which uses the live dteLoopNow. [R14]
    wire pplBlock = dteLoopNow | act_reg.channelLoop | ifcState.patternSend
                  | act_reg.v54Send | act_reg.ft1Send; // [R4]
    wire crlBlock = ifcState.lineLoop | ifcState.payloadLoop
                  | ifcState.repeaterLoop | ifcState.patternSend
                  | act_reg.portPayloadLoop; // [R6]
    wire remBlock = ifcState.patternSend | ifcState.remoteLineSend
                  | ifcState.payloadLoop | ifcState.repeaterLoop
                  | act_reg.portPayloadLoop;
    wire v54Block = remBlock | act_reg.ft1Send; // [R8]
    wire ft1Block = remBlock | act_reg.v54Send; // [R10]

    wire isStart  = req.start & ~req.stop;
    wire refuse   = isStart & (
                      ((req.test == `PLT_TEST_PPL) & pplBlock)
                    | ((req.test == `PLT_TEST_CRL) & crlBlock)
                    | ((req.test == `PLT_TEST_V54) & v54Block)
                    | ((req.test == `PLT_TEST_FT1) & ft1Block));
    wire grant    = isStart & ~refuse
                  & (req.test != `PLT_TEST_NONE);
    wire durDone  = timeoutEn & (durationMs != 16'h0)
                  & (msCount_reg >= durationMs);

    function automatic logic hit(input logic [2:0] t);
        hit = (req.test == t);
    endfunction

    always_comb
    begin
        act_next = act_reg;
        act_next.dteLoop = dteLoopNow;
        if (grant)
        begin
            if (hit(`PLT_TEST_PPL))
                act_next.portPayloadLoop = 1'b1;
            if (hit(`PLT_TEST_CRL))
                act_next.channelLoop = 1'b1;
            if (hit(`PLT_TEST_V54))
                act_next.v54Send = 1'b1;
            if (hit(`PLT_TEST_FT1))
                act_next.ft1Send = 1'b1;
            if (hit(`PLT_TEST_LAMP))
                act_next.lamp = 1'b1;
        end
        if (req.stop)
        begin
            if (hit(`PLT_TEST_PPL))
                act_next.portPayloadLoop = 1'b0;
            if (hit(`PLT_TEST_CRL))
                act_next.channelLoop = 1'b0;
            if (hit(`PLT_TEST_V54))
                act_next.v54Send = 1'b0;
            if (hit(`PLT_TEST_FT1))
                act_next.ft1Send = 1'b0;
            if (hit(`PLT_TEST_LAMP))
                act_next.lamp = 1'b0;
        end
        if (abortAll)
        begin
            act_next.portPayloadLoop = 1'b0;
            act_next.channelLoop = 1'b0;
            act_next.v54Send = 1'b0;
            act_next.ft1Send = 1'b0;
            act_next.lamp = 1'b0;
        end
        if (durDone)
            act_next.lamp = 1'b0; // [R13]
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            act_reg <= '0;
        else
            act_reg <= act_next;
    end

    // Software DTE loop obeys abort, but the lead path does not. [R3]
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            dteLoopSw_reg <= 1'b0;
        else if (abortAll)
            dteLoopSw_reg <= 1'b0;
        else
            dteLoopSw_reg <= dteLoopReq;
    end

    plt_tick_divider #(
        .DIV (LAMP_HALF)
    ) u_lampDiv (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .run      (act_reg.lamp),
        .tick     (lampTick)
    );

    plt_tick_divider #(
        .DIV (MS_CYC)
    ) u_msDiv (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .run      (act_reg.lamp),
        .tick     (msTick)
    );

    plt_code_sender u_v54 (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .enable   (act_reg.v54Send),
        .code     (`PLT_V54_CODE),
        .bitOut   (v54Bit)
    );

    plt_code_sender u_ft1 (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .enable   (act_reg.ft1Send),
        .code     (`PLT_FT1_CODE),
        .bitOut   (ft1Bit)
    );

    // Lamp phase and elapsed time restart at each lamp start.
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ledPhase_reg <= 1'b0;
            msCount_reg  <= 16'h0;
        end
        else if (!act_reg.lamp)
        begin
            ledPhase_reg <= 1'b1;
            msCount_reg  <= 16'h0;
        end
        else
        begin
            if (lampTick)
                ledPhase_reg <= ~ledPhase_reg; // [R11]
            if (msTick && msCount_reg != 16'hFFFF)
                msCount_reg <= msCount_reg + 16'h1;
        end
    end

    // Remote command codes take the network path while their send is active and no channel or port payload loop is; V.54 wins over FT1.
    wire netSel = act_reg.portPayloadLoop ? portRxData // [R2]
                : act_reg.v54Send ? v54Bit // [R7]
                : act_reg.ft1Send ? ft1Bit // [R9]
                : portTxData;
    // The DTE loop wins the DTE path since it also shields from the network.
    wire dteSel = act_reg.dteLoop ? dteRxData // [R1]
                : act_reg.channelLoop ? netRxData // [R5]
                : netRxData;
    // Channel loop turns the fully processed receive data back to the net.
    wire netOut = act_reg.channelLoop ? netRxData : netSel; // [R5]
    wire [LED_N-1:0] ledSel = act_reg.lamp ? {LED_N{ledPhase_reg}}
                            : ledNormal; // [R12]

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            dteTxData   <= 1'b0;
            netTxData   <= 1'b0;
            ledOut      <= '0;
            active      <= '0;
            reqRefused  <= 1'b0;
            reqAccepted <= 1'b0;
        end
        else
        begin
            dteTxData   <= dteSel;
            netTxData   <= netOut;
            ledOut      <= ledSel;
            active      <= act_reg;
            reqRefused  <= refuse;
            reqAccepted <= grant;
        end
    end

    sequence S_PPL_REQ;
        req.start && !req.stop && req.test == `PLT_TEST_PPL && pplBlock;
    endsequence

    AST_PPL_REFUSE: assert property (@(posedge core_clk) disable iff (sys_rst)
        S_PPL_REQ |=> !act_reg.portPayloadLoop || $past(act_reg.portPayloadLoop))
        else $error("Payload loop started despite conflict."); // [R4]
    AST_CRL_REFUSE: assert property (@(posedge core_clk) disable iff (sys_rst)
        (isStart && req.test == `PLT_TEST_CRL && crlBlock
         && !act_reg.channelLoop) |=> !act_reg.channelLoop)
        else $error("Channel loop started despite conflict."); // [R6]
    AST_V54_REFUSE: assert property (@(posedge core_clk) disable iff (sys_rst)
        (isStart && req.test == `PLT_TEST_V54 && v54Block
         && !act_reg.v54Send) |=> !act_reg.v54Send)
        else $error("V.54 send started despite conflict."); // [R8]
    AST_FT1_REFUSE: assert property (@(posedge core_clk) disable iff (sys_rst)
        (isStart && req.test == `PLT_TEST_FT1 && ft1Block
         && !act_reg.ft1Send) |=> !act_reg.ft1Send)
        else $error("FT1 send started despite conflict."); // [R10]
    AST_LEAD_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
        dteLoopLead |=> act_reg.dteLoop)
        else $error("Lead-held DTE loop dropped."); // [R3]
    AST_DTE_PATH: assert property (@(posedge core_clk) disable iff (sys_rst)
        act_reg.dteLoop |=> dteTxData == $past(dteRxData))
        else $error("DTE loop does not return DTE data."); // [R1]
    AST_PPL_PATH: assert property (@(posedge core_clk) disable iff (sys_rst)
        (act_reg.portPayloadLoop && !act_reg.channelLoop)
        |=> netTxData == $past(portRxData))
        else $error("Payload loop does not return port data."); // [R2]
    AST_CRL_PATH: assert property (@(posedge core_clk) disable iff (sys_rst)
        act_reg.channelLoop |=> netTxData == $past(netRxData))
        else $error("Channel loop does not return data."); // [R5]
    AST_V54_CODE: assert property (@(posedge core_clk) disable iff (sys_rst)
        (act_reg.v54Send && !act_reg.portPayloadLoop && !act_reg.channelLoop)
        [*2] |=> netTxData == $past(v54Bit))
        else $error("V.54 code not sent."); // [R7]
    AST_FT1_CODE: assert property (@(posedge core_clk) disable iff (sys_rst)
        (act_reg.ft1Send && !act_reg.v54Send && !act_reg.portPayloadLoop
         && !act_reg.channelLoop) |=> netTxData == $past(ft1Bit))
        else $error("FT1 code not sent."); // [R9]
    AST_LAMP_ALL: assert property (@(posedge core_clk) disable iff (sys_rst)
        act_reg.lamp |=> ledOut == {LED_N{$past(ledPhase_reg)}})
        else $error("LEDs not driven together."); // [R11]
    // Outputs stay at their reset value for one edge after release.
    AST_LAMP_END: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!act_reg.lamp && !$past(sys_rst)) |=> ledOut == $past(ledNormal))
        else $error("LEDs not restored after lamp test."); // [R12]
    AST_LAMP_TO: assert property (@(posedge core_clk) disable iff (sys_rst)
        (act_reg.lamp && durDone) |=> !act_reg.lamp)
        else $error("Lamp test outlived its duration."); // [R13]
    AST_REFUSE_STILL: assert property (@(posedge core_clk) disable iff (sys_rst)
        (refuse && !abortAll && !durDone) |=> act_reg.portPayloadLoop
        == $past(act_reg.portPayloadLoop) && act_reg.v54Send
        == $past(act_reg.v54Send) && act_reg.channelLoop
        == $past(act_reg.channelLoop) && act_reg.ft1Send
        == $past(act_reg.ft1Send) && act_reg.lamp == $past(act_reg.lamp))
        else $error("Refused request changed test state."); // [R14]
endmodule // plt_loop_manager

// >>> testbench/plt_far_end.sv
// Stand-in for the attached DTE and the network side bit streams.
`timescale 1ns/1ns
module plt_far_end (
    input  wire logic core_clk,
    input  wire logic slow,
    output logic      dteRxData,
    output logic      netRxData,
    output logic      portTxData,
    output logic      portRxData
);
    logic [1:0] holdCnt;

    initial
    begin
        holdCnt = 2'h0;
        {dteRxData, netRxData, portTxData, portRxData} = 4'h0;
    end

    // Slow mode holds each bit four cycles, as a sluggish far end would.
    always @(posedge core_clk)
    begin
        holdCnt <= holdCnt + 2'h1;
        if (!slow || holdCnt == 2'h0)
            {dteRxData, netRxData, portTxData, portRxData} <= 4'($urandom);
    end
endmodule // plt_far_end

// >>> testbench/tb_plt_loop_manager.sv
// Self-checking bench for the port loopback test manager.
`timescale 1ns/1ns
`include "plt_defs.svh"
module tb_plt_loop_manager
    import plt_pkg::*;
;
    logic           core_clk, sys_rst, dteLoopReq, dteLoopLead, abortAll;
    logic           timeoutEn, slow, dteRxData, netRxData, portTxData;
    logic           portRxData, dteTxData, netTxData, reqRefused, reqAccepted;
    plt_req_t       req;
    plt_ifc_state_t ifcState;
    plt_active_t    active, model;
    logic [15:0]    durationMs;
    logic [7:0]     ledNormal, ledOut;
    logic [3:0]     dly;
    logic           expQ[$];
    int             n_mismatch, n_checks, cyc;

    plt_far_end farEnd (.core_clk(core_clk), .slow(slow),
        .dteRxData(dteRxData), .netRxData(netRxData),
        .portTxData(portTxData), .portRxData(portRxData));

    plt_loop_manager #(.LED_N(8), .LAMP_HALF(4), .MS_CYC(2)) uut (
        .core_clk(core_clk), .sys_rst(sys_rst), .req(req),
        .dteLoopReq(dteLoopReq), .dteLoopLead(dteLoopLead),
        .abortAll(abortAll), .ifcState(ifcState), .timeoutEn(timeoutEn),
        .durationMs(durationMs), .dteRxData(dteRxData),
        .netRxData(netRxData), .portTxData(portTxData),
        .portRxData(portRxData), .ledNormal(ledNormal),
        .dteTxData(dteTxData), .netTxData(netTxData), .ledOut(ledOut),
        .active(active), .reqRefused(reqRefused),
        .reqAccepted(reqAccepted));

    task automatic stop_test();
        if (n_mismatch == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(string name, logic [7:0] exp, logic [7:0] got);
        n_checks++;
        if (exp !== got)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // A hung handshake must not stall the run forever.
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            stop_test();
        end
    end

    // Outputs are registered, so compare against inputs one edge old.
    always @(posedge core_clk)
        dly <= {dteRxData, netRxData, portTxData, portRxData};

    always @(posedge core_clk)
    begin
        if (!sys_rst && (reqAccepted || reqRefused))
        begin
            check("one answer", 8'h01,
                  {7'h0, reqAccepted ^ reqRefused});
            if (expQ.size() == 0)
                check("answer queue", 8'h00, 8'h01);
            else
                check("accept", {7'h0, expQ.pop_front()},
                      {7'h0, reqAccepted});
        end
    end

    function automatic logic ok(logic [2:0] t, plt_active_t a,
                                plt_ifc_state_t f);
        case (t)
            `PLT_TEST_PPL: return !(a.dteLoop | a.channelLoop | f.patternSend
                | a.v54Send | a.ft1Send);
            `PLT_TEST_CRL: return !(f.lineLoop | f.payloadLoop | f.repeaterLoop
                | f.patternSend | a.portPayloadLoop);
            `PLT_TEST_V54: return !(f.patternSend | f.remoteLineSend
                | f.payloadLoop | f.repeaterLoop | a.portPayloadLoop
                | a.ft1Send);
            `PLT_TEST_FT1: return !(f.patternSend | f.remoteLineSend
                | f.payloadLoop | f.repeaterLoop | a.portPayloadLoop
                | a.v54Send);
            default: return 1'b1;
        endcase
    endfunction

    task automatic start(logic [2:0] code, logic exp);
        @(posedge core_clk);
        req <= '{start: 1'b1, stop: 1'b0, test: code};
        expQ.push_back(exp);
        @(posedge core_clk);
        req <= '0;
        repeat (3) @(posedge core_clk);
    endtask

    task automatic abort_all();
        @(posedge core_clk);
        abortAll <= 1'b1;
        dteLoopReq <= 1'b0;
        @(posedge core_clk);
        abortAll <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask

    task automatic path(int sel, logic isDte);
        repeat (8)
        begin
            @(negedge core_clk);
            check("data path", {7'h0, dly[sel]},
                  {7'h0, isDte ? dteTxData : netTxData});
        end
    endtask

    task automatic code_chk(logic [7:0] code);
        logic [15:0] w;
        logic        hit;
        hit = 1'b0;
        w = 16'h0;
        repeat (16)
        begin
            @(negedge core_clk);
            w = {w[14:0], netTxData};
        end
        for (int r = 0; r < 8; r++)
            if (w[7:0] === 8'((code << r) | (code >> (8 - r))))
                hit = 1'b1;
        check("command bits", 8'h01,
              {7'h0, hit && (w[15:8] === w[7:0])});
    endtask

    task automatic lamp_chk();
        logic [7:0] prev;
        int         run;
        logic       seen;
        prev = ledOut;
        run = 0;
        seen = 1'b0;
        repeat (24)
        begin
            @(negedge core_clk);
            check("lamp level", 8'h01,
                  {7'h0, ledOut === 8'hFF || ledOut === 8'h00});
            if (ledOut !== prev)
            begin
                if (seen)
                    check("lamp half", 8'h04, 8'(run));
                seen = 1'b1;
                run = 0;
            end
            run++;
            prev = ledOut;
        end
        check("lamp toggles", 8'h01, {7'h0, seen});
    endtask

    initial
    begin
        logic [2:0] t;
        logic       e;
        sys_rst = 1'b1;
        req = '0;
        {dteLoopReq, dteLoopLead, abortAll, timeoutEn, slow} = 5'h0;
        ifcState = '0;
        durationMs = 16'h0;
        ledNormal = 8'h5A;
        model = '0;
        void'($urandom(32'h8EFD));
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        path(1, 1'b0);
        path(2, 1'b1);
        start(`PLT_TEST_PPL, 1'b1);
        path(0, 1'b0);
        abort_all();
        start(`PLT_TEST_CRL, 1'b1);
        path(2, 1'b0);
        abort_all();
        start(`PLT_TEST_V54, 1'b1);
        code_chk(`PLT_V54_CODE);
        abort_all();
        start(`PLT_TEST_FT1, 1'b1);
        code_chk(`PLT_FT1_CODE);
        abort_all();
        dteLoopLead <= 1'b1;
        repeat (4) @(posedge core_clk);
        path(3, 1'b1);
        abort_all();
        check("lead loop", 8'h01, {7'h0, active.dteLoop});
        path(3, 1'b1);
        @(posedge core_clk);
        dteLoopLead <= 1'b0;
        dteLoopReq <= 1'b1;
        repeat (4) @(posedge core_clk);
        check("soft loop", 8'h01, {7'h0, active.dteLoop});
        abort_all();
        check("soft abort", 8'h00, {7'h0, active.dteLoop});
        // Sparse interface conflicts keep both outcomes well exercised.
        repeat (48)
        begin
            @(posedge core_clk);
            ifcState <= plt_ifc_state_t'(5'($urandom & $urandom & $urandom));
            dteLoopLead <= ($urandom % 4) == 0;
            slow <= 1'($urandom);
            repeat (4) @(posedge core_clk);
            model.dteLoop = dteLoopLead;
            t = 3'($urandom_range(1, 4));
            e = ok(t, model, ifcState);
            start(t, e);
            if (e)
                case (t)
                    `PLT_TEST_PPL: model.portPayloadLoop = 1'b1;
                    `PLT_TEST_CRL: model.channelLoop = 1'b1;
                    `PLT_TEST_V54: model.v54Send = 1'b1;
                    default: model.ft1Send = 1'b1;
                endcase
            check("active", {2'h0, model}, {2'h0, active});
            if (($urandom % 4) == 0)
            begin
                abort_all();
                model = '0;
            end
        end
        abort_all();
        ifcState <= '0;
        dteLoopLead <= 1'b0;
        start(`PLT_TEST_LAMP, 1'b1);
        lamp_chk();
        abort_all();
        check("led restore", ledNormal, ledOut);
        timeoutEn <= 1'b1;
        durationMs <= 16'h0008;
        start(`PLT_TEST_LAMP, 1'b1);
        check("lamp running", 8'h01, {7'h0, active.lamp});
        repeat (20) @(posedge core_clk);
        check("lamp timeout", 8'h00, {7'h0, active.lamp});
        check("led after timeout", ledNormal, ledOut);
        // A request that never got an answer must not slip through.
        check("pending answers", 8'h00, 8'(expQ.size()));
        stop_test();
    end
endmodule // tb_plt_loop_manager
